// >>> core/dppc_defs.svh
// constants for the downstream port power control block
`ifndef DPPC_DEFS_SVH
`define DPPC_DEFS_SVH

// port counts
`define DPPC_NPORTS          6
`define DPPC_NSS             3
`define DPPC_SS_FIRST        2

// timing
`define DPPC_CLK_NS          100
`define DPPC_SETTLE_NS       500
`define DPPC_SETTLE_CYC      ((`DPPC_SETTLE_NS + `DPPC_CLK_NS - 1) / `DPPC_CLK_NS)
`define DPPC_CNT_W           4

// register byte offsets
`define DPPC_OFS_CTRL        8'h00
`define DPPC_OFS_SS_POWER    8'h04
`define DPPC_OFS_OC_STATUS   8'h08
`define DPPC_OFS_OC_MASK     8'h0C
`define DPPC_OFS_PIN_STATE   8'h10

// field positions
`define DPPC_CTRL_SPLIT_BIT  0
`define DPPC_CTRL_EN_LSB     8
`define DPPC_PINS_EN_LSB     0
`define DPPC_PINS_OC_LSB     8
`define DPPC_PINS_SS_LSB     16

// reset values
`define DPPC_RST_SPLIT       1'h0
`define DPPC_RST_CFG_EN      6'h3F
`define DPPC_RST_SS_REQ      3'h0
`define DPPC_RST_MASK        6'h00

`endif

// >>> core/dppc_pkg.sv
// types for the downstream port power control block
`include "dppc_defs.svh"

package dppc_pkg;

    typedef enum logic [1:0] {
        PS_OFF    = 2'b00,
        PS_SETTLE = 2'b01,
        PS_ON     = 2'b10
    } dppc_port_state_type;

    typedef enum logic [2:0] {
        RS_CTRL   = 3'b000,
        RS_SS     = 3'b001,
        RS_STAT   = 3'b010,
        RS_MASK   = 3'b011,
        RS_PINS   = 3'b100,
        RS_NONE   = 3'b111
    } dppc_reg_sel_type;

    typedef struct packed {
        logic [`DPPC_NPORTS-1:0]                      sync1;
        logic [`DPPC_NPORTS-1:0]                      sync2;
        logic [`DPPC_NPORTS-1:0]                      sync3;
        logic [`DPPC_NPORTS-1:0]                      pin_lvl;
        dppc_port_state_type [`DPPC_NPORTS-1:0]       pstate;
        logic [`DPPC_NPORTS-1:0][`DPPC_CNT_W-1:0]     settle;
        logic                                         split;
        logic [`DPPC_NPORTS-1:0]                      cfg_en;
        logic [`DPPC_NSS-1:0]                         ss_req;
        logic [`DPPC_NPORTS-1:0]                      oc_status;
        logic [`DPPC_NPORTS-1:0]                      oc_mask;
        logic [`DPPC_NPORTS-1:0]                      pin_o;
        logic [`DPPC_NPORTS-1:0]                      pin_oe;
        logic [`DPPC_NPORTS-1:0]                      u2_pwr;
        logic [`DPPC_NPORTS-1:0]                      u3_pwr;
        logic [`DPPC_NSS-1:0]                         ss_en;
        logic                                         irq;
        logic [31:0]                                  prdata;
        logic                                         pready;
        logic                                         pslverr;
    } dppc_state_type;

endpackage : dppc_pkg

// >>> core/dppc_port_power.sv
// downstream port power enable and overcurrent sense with apb registers
//
// What this block does
// - enabled port: pin released, pull-up powers port
// - enabled port: low pin level means overcurrent
// - disabled port: pin becomes output driven low
// - split off: pin powers both port halves
// - split on: pin powers usb 2.0 half only
// - ports 3-5 get requested superspeed enable in split
// - split off: superspeed enables idle low
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "dppc_defs.svh"

module dppc_port_power (
    input  wire logic                          CLK,
    input  wire logic                          RESET_N,
    input  wire logic                          PSEL,
    input  wire logic                          PENABLE,
    input  wire logic                          PWRITE,
    input  wire logic [7:0]                    PADDR,
    input  wire logic [31:0]                   PWDATA,
    output      logic [31:0]                   PRDATA,
    output      logic                          PREADY,
    output      logic                          PSLVERR,
    input  wire logic [`DPPC_NPORTS-1:0]       HOST_PORT_POWER,
    input  wire logic [`DPPC_NPORTS-1:0]       OC_CLEAR,
    input  wire logic [`DPPC_NPORTS-1:0]       PORT_PWR_I,
    output      logic [`DPPC_NPORTS-1:0]       PORT_PWR_O,
    output      logic [`DPPC_NPORTS-1:0]       PORT_PWR_OE,
    output      logic                          PORT3_SUPERSPEED_POWER_ENABLE,
    output      logic                          PORT4_SUPERSPEED_POWER_ENABLE,
    output      logic                          PORT5_SUPERSPEED_POWER_ENABLE,
    output      logic [`DPPC_NPORTS-1:0]       U2_POWERED,
    output      logic [`DPPC_NPORTS-1:0]       U3_POWERED,
    output      logic [`DPPC_NPORTS-1:0]       OC_FLAG,
    output      logic                          IRQ
);
    import dppc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode, shared by read and write paths

    function automatic dppc_pkg::dppc_reg_sel_type reg_sel(input logic [7:0] addr);
        dppc_pkg::dppc_reg_sel_type s;
        s = RS_NONE;
        case (addr)
            `DPPC_OFS_CTRL: begin
                s = RS_CTRL;
            end
            `DPPC_OFS_SS_POWER: begin
                s = RS_SS;
            end
            `DPPC_OFS_OC_STATUS: begin
                s = RS_STAT;
            end
            `DPPC_OFS_OC_MASK: begin
                s = RS_MASK;
            end
            `DPPC_OFS_PIN_STATE: begin
                s = RS_PINS;
            end
            default: begin
                s = RS_NONE;
            end
        endcase
        return s;
    endfunction : reg_sel

    // settle counts as powered: the switch is already on, only sensing waits
    function automatic logic port_live(input dppc_pkg::dppc_port_state_type st);
        return (st == PS_SETTLE) || (st == PS_ON);
    endfunction : port_live

    // superspeed enables moved onto the positions of the ports they serve
    function automatic logic [`DPPC_NPORTS-1:0] ss_spread(input logic [`DPPC_NSS-1:0] ss);
        logic [`DPPC_NPORTS-1:0] w;
        w = '0;
        w[`DPPC_SS_FIRST +: `DPPC_NSS] = ss;
        return w;
    endfunction : ss_spread

    ////////////////////////////////////////////////////////////////////////////////
    // state

    localparam logic [`DPPC_CNT_W-1:0] SETTLE_LAST = `DPPC_CNT_W'(`DPPC_SETTLE_CYC - 1);

    dppc_state_type                    s_q;
    dppc_state_type                    s_d;
    dppc_reg_sel_type                  sel;
    logic                              access;
    logic                              commit;
    logic [`DPPC_NPORTS-1:0]           port_en;
    logic [`DPPC_NPORTS-1:0]           oc_evt;
    logic [`DPPC_NPORTS-1:0]           oc_clr;
    logic [`DPPC_NPORTS-1:0]           oc_live;
    logic [`DPPC_NPORTS-1:0]           powered;
    logic [31:0]                       rdata;
    logic [`DPPC_NPORTS-1:0]           ss_wide;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        // defaults: hold state, no event, nothing powered
        s_d     = s_q;
        sel     = reg_sel(PADDR);
        access  = PSEL & PENABLE;
        commit  = access & s_q.pready;
        oc_evt  = '0;
        oc_live = '0;
        powered = '0;
        rdata   = 32'h0000_0000;
        ss_wide = ss_spread(s_q.ss_en);

        ////////////////////////////////////////////////////////////////////////////
        // pin sampling: three stages, change taken when stages two and three agree

        s_d.sync1 = PORT_PWR_I;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        for (int i = 0; i < `DPPC_NPORTS; i++) begin
            if (s_q.sync2[i] == s_q.sync3[i]) begin
                s_d.pin_lvl[i] = s_q.sync3[i];
            end
        end

        ////////////////////////////////////////////////////////////////////////////
        // per-port power state

        // a port runs only with both configuration and host power granted
        port_en = s_q.cfg_en & HOST_PORT_POWER;

        for (int i = 0; i < `DPPC_NPORTS; i++) begin
            powered[i] = port_live(s_q.pstate[i]);
            case (s_q.pstate[i])
                PS_OFF: begin
                    s_d.pin_oe[i] = 1'b1;
                    if (port_en[i]) begin
                        s_d.pstate[i] = PS_SETTLE;
                        s_d.settle[i] = '0;
                        s_d.pin_oe[i] = 1'b0;
                    end
                end
                PS_SETTLE: begin
                    // sampled level still shows our own drive low; wait it out
                    if (!port_en[i]) begin
                        s_d.pstate[i] = PS_OFF;
                        s_d.pin_oe[i] = 1'b1;
                    end else if (s_q.settle[i] == SETTLE_LAST) begin
                        s_d.pstate[i] = PS_ON;
                    end else begin
                        s_d.settle[i] = s_q.settle[i] + `DPPC_CNT_W'(1);
                    end
                end
                PS_ON: begin
                    if (!port_en[i]) begin
                        s_d.pstate[i] = PS_OFF;
                        s_d.pin_oe[i] = 1'b1;
                    end else begin
                        s_d.pin_oe[i] = 1'b0;
                        oc_live[i]    = ~s_q.pin_lvl[i];
                        oc_evt[i]     = ~s_q.pin_lvl[i];
                    end
                end
                default: begin
                    s_d.pstate[i] = PS_OFF;
                    s_d.pin_oe[i] = 1'b1;
                end
            endcase
        end
        // open drain: the pin is only ever pulled low, never driven high
        s_d.pin_o = '0;

        ////////////////////////////////////////////////////////////////////////////
        // power indication for the two halves of each port

        for (int i = 0; i < `DPPC_NPORTS; i++) begin
            s_d.u2_pwr[i] = powered[i];
            if (!s_q.split) begin
                s_d.u3_pwr[i] = powered[i];
            end else begin
                // split ports without a separate switch have no superspeed power
                s_d.u3_pwr[i] = ss_wide[i];
            end
        end

        // superspeed enables follow the request only in split mode
        for (int k = 0; k < `DPPC_NSS; k++) begin
            s_d.ss_en[k] = s_q.split & s_q.ss_req[k];
        end

        ////////////////////////////////////////////////////////////////////////////
        // apb slave: one wait state, write and read-clear at the pready edge

        case (sel)
            RS_CTRL: begin
                rdata[`DPPC_CTRL_SPLIT_BIT] = s_q.split;
                rdata[`DPPC_CTRL_EN_LSB +: `DPPC_NPORTS] = s_q.cfg_en;
            end
            RS_SS: begin
                rdata[`DPPC_NSS-1:0] = s_q.ss_req;
            end
            RS_STAT: begin
                rdata[`DPPC_NPORTS-1:0] = s_q.oc_status;
            end
            RS_MASK: begin
                rdata[`DPPC_NPORTS-1:0] = s_q.oc_mask;
            end
            RS_PINS: begin
                rdata[`DPPC_PINS_EN_LSB +: `DPPC_NPORTS] = powered;
                rdata[`DPPC_PINS_OC_LSB +: `DPPC_NPORTS] = oc_live;
                rdata[`DPPC_PINS_SS_LSB +: `DPPC_NSS]    = s_q.ss_en;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase

        // answer one cycle after the access phase opens; no back pressure
        if (access && !s_q.pready) begin
            s_d.pready  = 1'b1;
            s_d.pslverr = (sel == RS_NONE);
            s_d.prdata  = PWRITE ? 32'h0000_0000 : rdata;
        end else begin
            s_d.pready  = 1'b0;
            s_d.pslverr = 1'b0;
            s_d.prdata  = 32'h0000_0000;
        end

        // writes take effect only at the edge that completes the transfer
        if (commit && PWRITE) begin
            case (sel)
                RS_CTRL: begin
                    s_d.split  = PWDATA[`DPPC_CTRL_SPLIT_BIT];
                    s_d.cfg_en = PWDATA[`DPPC_CTRL_EN_LSB +: `DPPC_NPORTS];
                end
                RS_SS: begin
                    s_d.ss_req  = PWDATA[`DPPC_NSS-1:0];
                end
                RS_MASK: begin
                    s_d.oc_mask = PWDATA[`DPPC_NPORTS-1:0];
                end
                default: begin
                    s_d.ss_req  = s_q.ss_req;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////
        // sticky overcurrent status; a read clears only the bits it reported

        // the hub status logic clears by pin, software by reading
        oc_clr = OC_CLEAR;
        if (commit && !PWRITE && sel == RS_STAT) begin
            oc_clr = oc_clr | s_q.prdata[`DPPC_NPORTS-1:0];
        end
        // set wins over a clear landing in the same cycle
        s_d.oc_status = (s_q.oc_status & ~oc_clr) | oc_evt;
        s_d.irq       = |(s_d.oc_status & s_d.oc_mask);

        ////////////////////////////////////////////////////////////////////////////
        // synchronous reset

        // reset last so it overrides every update above
        if (!RESET_N) begin
            s_d           = '0;
            s_d.sync1     = '1;
            s_d.sync2     = '1;
            s_d.sync3     = '1;
            s_d.pin_lvl   = '1;
            s_d.pin_oe    = '1;
            s_d.split     = `DPPC_RST_SPLIT;
            s_d.cfg_en    = `DPPC_RST_CFG_EN;
            s_d.ss_req    = `DPPC_RST_SS_REQ;
            s_d.oc_mask   = `DPPC_RST_MASK;
        end
    end

    always_ff @(posedge CLK) begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign PRDATA                        = s_q.prdata;
    assign PREADY                        = s_q.pready;
    assign PSLVERR                       = s_q.pslverr;
    assign PORT_PWR_O                    = s_q.pin_o;
    assign PORT_PWR_OE                   = s_q.pin_oe;
    assign PORT3_SUPERSPEED_POWER_ENABLE = s_q.ss_en[0];
    assign PORT4_SUPERSPEED_POWER_ENABLE = s_q.ss_en[1];
    assign PORT5_SUPERSPEED_POWER_ENABLE = s_q.ss_en[2];
    assign U2_POWERED                    = s_q.u2_pwr;
    assign U3_POWERED                    = s_q.u3_pwr;
    assign OC_FLAG                       = s_q.oc_status;
    assign IRQ                           = s_q.irq;

endmodule : dppc_port_power

// >>> dv/dppc_port_power_checker.sv
// assertion checker for the port power block
`timescale 1ns/10ps
module dppc_port_power_checker (
    input wire logic       CLK,
    input wire logic       RESET_N,
    input wire logic       PWRITE,
    input wire logic       PREADY,
    input wire logic [5:0] HOST_PORT_POWER,
    input wire logic [5:0] OC_CLEAR,
    input wire logic [5:0] PORT_PWR_O,
    input wire logic [5:0] PORT_PWR_OE,
    input wire logic       PORT3_SUPERSPEED_POWER_ENABLE,
    input wire logic       PORT4_SUPERSPEED_POWER_ENABLE,
    input wire logic       PORT5_SUPERSPEED_POWER_ENABLE,
    input wire logic [5:0] U2_POWERED,
    input wire logic [5:0] U3_POWERED,
    input wire logic [5:0] OC_FLAG,
    input wire logic       IRQ
);
    wire logic [2:0] ss = {PORT5_SUPERSPEED_POWER_ENABLE, PORT4_SUPERSPEED_POWER_ENABLE,
                           PORT3_SUPERSPEED_POWER_ENABLE};
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////////////////////////
    chk_pin_low_only: assert property (PORT_PWR_O == 6'h00)
        else $error("combined pin driven high");
    chk_off_drives: assert property (&(PORT_PWR_OE | $past(HOST_PORT_POWER)))
        else $error("powered-off port pin not driven");
    chk_power_release: assert property ((U2_POWERED & $past(PORT_PWR_OE)) == 6'h00)
        else $error("port powered while pin driven low");
    chk_split_ss: assert property ($stable(ss) && ss != 3'h0 |-> U3_POWERED == {1'b0, ss, 2'b00})
        else $error("superspeed power differs from its enable");
    chk_joint_power: assert property (ss == 3'h0 && $past(ss) == 3'h0 && U3_POWERED != 6'h00
        |-> U3_POWERED == U2_POWERED)
        else $error("port halves powered apart");
    chk_irq_cause: assert property (IRQ |-> (|OC_FLAG) || $past(|OC_FLAG))
        else $error("interrupt without overcurrent");
    chk_flag_sticky: assert property ((($past(OC_FLAG) & ~OC_FLAG & ~$past(OC_CLEAR)) == 6'h00)
        || $past(PREADY && !PWRITE))
        else $error("overcurrent flag lost");
    chk_oc_when_on: assert property ((OC_FLAG & ~$past(OC_FLAG) & $past(PORT_PWR_OE)
        & $past(PORT_PWR_OE, 2)) == 6'h00)
        else $error("overcurrent on unpowered port");
endmodule : dppc_port_power_checker

bind dppc_port_power dppc_port_power_checker dppc_port_power_checker_i (.CLK(CLK),
    .RESET_N(RESET_N), .PWRITE(PWRITE), .PREADY(PREADY), .HOST_PORT_POWER(HOST_PORT_POWER),
    .OC_CLEAR(OC_CLEAR), .PORT_PWR_O(PORT_PWR_O), .PORT_PWR_OE(PORT_PWR_OE),
    .PORT3_SUPERSPEED_POWER_ENABLE(PORT3_SUPERSPEED_POWER_ENABLE),
    .PORT4_SUPERSPEED_POWER_ENABLE(PORT4_SUPERSPEED_POWER_ENABLE),
    .PORT5_SUPERSPEED_POWER_ENABLE(PORT5_SUPERSPEED_POWER_ENABLE),
    .U2_POWERED(U2_POWERED), .U3_POWERED(U3_POWERED), .OC_FLAG(OC_FLAG), .IRQ(IRQ));

// >>> dv/dppc_switch_model.sv
// external power switches with current monitors, one per port
`timescale 1ns/10ps
module dppc_switch_model (
    input  wire logic [5:0] pin_o,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] fault,
    output      logic [5:0] pin_lvl
);
    // hub drive wins, else monitor pulls low on fault, else pull-up
    assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ~fault);
endmodule : dppc_switch_model

// >>> dv/dppc_port_power_bench.sv
// self-checking bench for the port power block
`timescale 1ns/10ps
module dppc_port_power_bench;
    logic clk, rst_n, psel, penable, pwrite, PREADY, PSLVERR, IRQ, s3, s4, s5;
    logic [7:0]  paddr;
    logic [31:0] pwdata, PRDATA;
    logic [5:0]  host, oc_clr, fault, lvl, PO, OE, U2, U3, OC_FLAG, onep, oneq;
    logic [2:0]  ssv;
    logic [32:0] exp_q[$];
    int error_cnt = 0, cmp_count = 0, p;
    dppc_port_power dppc_port_power_i (.CLK(clk), .RESET_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .HOST_PORT_POWER(host), .OC_CLEAR(oc_clr),
        .PORT_PWR_I(lvl), .PORT_PWR_O(PO), .PORT_PWR_OE(OE),
        .PORT3_SUPERSPEED_POWER_ENABLE(s3), .PORT4_SUPERSPEED_POWER_ENABLE(s4),
        .PORT5_SUPERSPEED_POWER_ENABLE(s5), .U2_POWERED(U2), .U3_POWERED(U3),
        .OC_FLAG(OC_FLAG), .IRQ(IRQ));
    dppc_switch_model dppc_switch_model_i (.pin_o(PO), .pin_oe(OE), .fault(fault),
        .pin_lvl(lvl));
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp_reg(input logic [32:0] g, input logic [32:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp_reg
    task automatic cmp_pin(input logic [5:0] g, input logic [5:0] e);
        cmp_reg({27'h0, g}, {27'h0, e});
    endtask : cmp_pin
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (PREADY !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic tally_and_finish;
        if (exp_q.size() != 0)
            error_cnt++;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    // one note per transfer, response word plus error bit
    always @(posedge clk) begin
        if (PREADY === 1'b1 && exp_q.size() > 0)
            cmp_reg({PSLVERR, PRDATA}, exp_q.pop_front());
    end
    initial begin
        #5000000;
        error_cnt++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {clk, rst_n, psel, penable, pwrite, paddr, pwdata, host, oc_clr, fault} = '0;
        void'($urandom(62314));
        p = $urandom % 6;
        ssv = 3'($urandom % 8);
        onep = 6'h01 << p;
        oneq = 6'h01 << ((p + 1) % 6);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cmp_pin(OE, 6'h3F);
        apb(1'b0, 8'h00, 32'h0, 33'h000003F00);
        apb(1'b1, 8'h14, 32'hFFFFFFFF, 33'h100000000);
        apb(1'b0, 8'h15, 32'h0, 33'h100000000);
        $display("test reset done");
        host <= 6'h3F;
        repeat (10) @(posedge clk);
        cmp_pin(OE, 6'h00);
        cmp_pin(U3, 6'h3F);
        cmp_pin(U2, 6'h3F);
        cmp_pin({3'h0, s5, s4, s3}, 6'h00);
        $display("test power on done");
        apb(1'b1, 8'h00, 32'h00003F01, 33'h0);
        apb(1'b1, 8'h04, {29'h0, ssv}, 33'h0);
        repeat (3) @(posedge clk);
        cmp_pin({3'h0, s5, s4, s3}, {3'h0, ssv});
        cmp_pin(U3, {1'b0, ssv, 2'b00});
        cmp_pin(U2, 6'h3F);
        apb(1'b0, 8'h04, 32'h0, {30'h0, ssv});
        apb(1'b0, 8'h10, 32'h0, {14'h0, ssv, 10'h0, 6'h3F});
        apb(1'b1, 8'h00, 32'h00003F00, 33'h0);
        repeat (3) @(posedge clk);
        cmp_pin({3'h0, s5, s4, s3}, 6'h00);
        cmp_pin(U3, 6'h3F);
        $display("test split done");
        apb(1'b1, 8'h0C, 32'h3F, 33'h0);
        for (int k = 0; k < 2; k++) begin
            fault <= onep;
            repeat (12) @(posedge clk);
            apb(1'b0, 8'h10, 32'h0, {19'h0, onep, 2'h0, 6'h3F});
            fault <= 6'h00;
            repeat (12) @(posedge clk);
            cmp_pin(OC_FLAG, onep);
            cmp_pin({5'h0, IRQ}, 6'h01);
            if (k == 0) begin
                apb(1'b0, 8'h08, 32'h0, {27'h0, onep});
                cmp_pin(OC_FLAG, 6'h00);
            end
            oc_clr <= onep;
            @(posedge clk);
            oc_clr <= 6'h00;
            repeat (2) @(posedge clk);
            cmp_pin(OC_FLAG, 6'h00);
            cmp_pin({5'h0, IRQ}, 6'h00);
        end
        $display("test overcurrent done");
        apb(1'b1, 8'h00, {18'h0, ~oneq, 8'h00}, 33'h0);
        fault <= oneq;
        repeat (12) @(posedge clk);
        cmp_pin(OE, oneq);
        cmp_pin(OC_FLAG, 6'h00);
        host <= ~onep;
        repeat (3) @(posedge clk);
        cmp_pin(OE, onep | oneq);
        cmp_pin(U2, ~(onep | oneq));
        $display("test disable done");
        tally_and_finish();
    end
endmodule : dppc_port_power_bench
